// [test/ivc_core_model.sv]
// Purpose: Behavioural core sequencer and return stack facing the controller
// Assumes: Same clock domain as the controller, stack depth set by DEPTH
// Notes: Bench commands returns and sleep; stack fill follows real takes
`timescale 1ns/1ns
module ivc_core_model #(
  parameter int DEPTH = 1
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire ivc_pkg::ivc_core_out_s coreOut,
  input wire logic retiCmd,
  input wire logic sleepCmd,
  output ivc_pkg::ivc_core_in_s coreIn
);
  logic [3:0] level;
  logic [3:0] next_level;

  // ==========================================================
  // Stack depth: a take pushes the next PC, a pop restores it
  always_comb begin
    next_level = level;
    if (coreOut.takeIrq) begin
      next_level = level + 4'h1;
    end else if (coreOut.popStack && level != 4'h0) begin
      next_level = level - 4'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      level <= 4'h0;
    end else begin
      level <= next_level;
    end
  end

  // A return with an empty stack is impossible on the real core
  assign coreIn.retiExec = retiCmd && (level != 4'h0);
  assign coreIn.stackFull = (level >= 4'(DEPTH));
  assign coreIn.sleepMode = sleepCmd;
endmodule

// [test/tb.sv]
// Purpose: Self-checking bench for the vectored interrupt controller
// Assumes: Three timers, default vector map, stack of one level
// Notes: APB master tasks; take latency measured in clocks from the event
`timescale 1ns/1ns
module tb;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic pin = 1'b0;
  logic tbEvt = 1'b0;
  logic retiCmd = 1'b0;
  logic sleepCmd = 1'b0;
  logic [2:0] ovf = 3'h0;
  ivc_pkg::ivc_core_in_s coreIn;
  ivc_pkg::ivc_core_out_s coreOut;
  logic [31:0] q;
  logic e;
  logic [7:0] vecs [0:2];
  int n;
  int errTotal = 0;
  int nChecks = 0;

  always #2 clk = ~clk;

  ivc_controller u_ivc_controller (.clk(clk), .sys_rst(sys_rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .sharedIrqPin(pin),
    .timerOvf(ovf), .timebaseEvt(tbEvt), .coreIn(coreIn), .coreOut(coreOut));

  ivc_core_model #(.DEPTH(1)) u_ivc_core_model (.clk(clk), .sys_rst(sys_rst),
    .coreOut(coreOut), .retiCmd(retiCmd), .sleepCmd(sleepCmd), .coreIn(coreIn));

  // ==========================================================
  // Bus and core helpers
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    nChecks++;
    if (seen !== exp) begin
      errTotal++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Take is a one-clock pulse, so every edge is looked at
  task automatic wait_take(input int lim);
    n = 0;
    while (coreOut.takeIrq !== 1'b1 && n < lim) begin
      @(posedge clk);
      n++;
    end
  endtask

  task automatic return_from_interrupt;
    int k;
    k = 0;
    @(posedge clk);
    retiCmd <= 1'b1;
    @(posedge clk);
    retiCmd <= 1'b0;
    while (coreOut.popStack !== 1'b1 && k < 4) begin
      @(posedge clk);
      k++;
    end
    check("pop after return", 32'(k < 4), 32'h1);
  endtask

  task automatic pulse(input logic [2:0] m, input logic t);
    @(posedge clk);
    ovf <= m;
    tbEvt <= t;
    @(posedge clk);
    ovf <= 3'h0;
    tbEvt <= 1'b0;
  endtask

  // Read-modify-write keeps pending flags intact
  task automatic set_global;
    apb(ivc_pkg::ADDR_CTRL_A, 1'b0, 32'h0);
    apb(ivc_pkg::ADDR_CTRL_A, 1'b1, q | 32'h1);
  endtask

  task report_and_stop;
    $display("checks %0d mismatches %0d", nChecks, errTotal);
    if (errTotal == 0 && nChecks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // ==========================================================
  // Watchdog, far beyond the expected run of a few hundred clocks
  initial begin
    repeat (20000) @(posedge clk);
    errTotal++;
    report_and_stop;
  end

  // ==========================================================
  // Test sequence
  initial begin
    vecs[0] = ivc_pkg::VEC_T1;
    vecs[1] = ivc_pkg::VEC_T2;
    vecs[2] = ivc_pkg::VEC_TB_THREE;
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    // Reset values and an unmapped word
    apb(ivc_pkg::ADDR_CTRL_A, 1'b0, 32'h0);
    check("ctrl A reset", q, 32'h0);
    apb(ivc_pkg::ADDR_CTRL_ONE, 1'b0, 32'h0);
    check("ctrl one reset", q[7:0], ivc_pkg::CTRL_ONE_RESET);
    apb(12'h010, 1'b0, 32'h0);
    check("unmapped error", 32'(e), 32'h1);
    check("unmapped data", q, 32'h0);
    $display("test reset done");
    // Flags latch while globally and individually disabled
    pulse(3'h7, 1'b1);
    repeat (4) @(posedge clk);
    apb(ivc_pkg::ADDR_CTRL_A, 1'b0, 32'h0);
    check("flags A", q[7:0], 8'h60);
    apb(ivc_pkg::ADDR_CTRL_B, 1'b0, 32'h0);
    check("flags B", q[7:0], 8'h50);
    apb(ivc_pkg::ADDR_CTRL_A, 1'b1, 32'h61);
    wait_take(24);
    check("no take, sources off", n, 24);
    apb(ivc_pkg::ADDR_CTRL_A, 1'b0, 32'h0);
    check("flags held", q[7:0], 8'h61);
    $display("test latch done");
    // Pin direction is set outside this block by software
    apb(ivc_pkg::ADDR_CTRL_ONE, 1'b1, 32'h40);
    pin <= 1'b1;
    repeat (8) @(posedge clk);
    apb(ivc_pkg::ADDR_CTRL_A, 1'b1, 32'h7F);
    apb(ivc_pkg::ADDR_CTRL_B, 1'b1, 32'h55);
    wait_take(20);
    check("ext first", coreOut.irqVector, ivc_pkg::VEC_EXT);
    // Status: idle, external index, last vector in the low byte
    apb(ivc_pkg::ADDR_STATUS, 1'b0, 32'h0);
    check("status", q, {24'h0, ivc_pkg::VEC_EXT});
    apb(ivc_pkg::ADDR_CTRL_A, 1'b0, 32'h0);
    check("ext serviced", q[7:0], 8'h6E);
    set_global;
    wait_take(24);
    check("no take, stack full", n, 24);
    return_from_interrupt;
    wait_take(20);
    check("timer0 next", coreOut.irqVector, ivc_pkg::VEC_T0);
    for (int i = 0; i < 3; i++) begin
      return_from_interrupt;
      set_global;
      wait_take(20);
      check("priority order", coreOut.irqVector, vecs[i]);
    end
    return_from_interrupt;
    apb(ivc_pkg::ADDR_CTRL_A, 1'b0, 32'h0);
    check("A cleared", q[7:0], 8'h0E);
    apb(ivc_pkg::ADDR_CTRL_B, 1'b0, 32'h0);
    check("B cleared", q[7:0], 8'h05);
    $display("test priority done");
    // Every edge select code against a rise and a fall
    apb(ivc_pkg::ADDR_CTRL_A, 1'b1, 32'h0);
    pin <= 1'b0;
    for (int c = 0; c < 4; c++) begin
      apb(ivc_pkg::ADDR_CTRL_ONE, 1'b1, {24'h0, c[1:0], 6'h00});
      apb(ivc_pkg::ADDR_CTRL_ONE, 1'b0, 32'h0);
      check("edge code", q[7:6], c[1:0]);
      apb(ivc_pkg::ADDR_CTRL_A, 1'b1, 32'h0);
      pin <= 1'b1;
      repeat (8) @(posedge clk);
      apb(ivc_pkg::ADDR_CTRL_A, 1'b0, 32'h0);
      check("rise flag", q[4], c[0]);
      apb(ivc_pkg::ADDR_CTRL_A, 1'b1, 32'h0);
      pin <= 1'b0;
      repeat (8) @(posedge clk);
      apb(ivc_pkg::ADDR_CTRL_A, 1'b0, 32'h0);
      check("fall flag", q[4], c[1]);
    end
    $display("test edge done");
    // Latency while running, then while asleep
    apb(ivc_pkg::ADDR_CTRL_A, 1'b1, 32'h05);
    pulse(3'h1, 1'b0);
    wait_take(30);
    // Two to three cycles of four clocks, plus one clock to sample
    check("run latency", 32'(n >= 9 && n <= 13), 32'h1);
    check("run vector", coreOut.irqVector, ivc_pkg::VEC_T0);
    return_from_interrupt;
    sleepCmd <= 1'b1;
    apb(ivc_pkg::ADDR_CTRL_A, 1'b1, 32'h05);
    pulse(3'h1, 1'b0);
    repeat (2) @(posedge clk);
    check("wake request", 32'(coreOut.wakeReq), 32'h1);
    wait_take(30);
    check("wake latency", 32'(n >= 8 && n <= 16), 32'h1);
    check("wake vector", coreOut.irqVector, ivc_pkg::VEC_T0);
    sleepCmd <= 1'b0;
    return_from_interrupt;
    $display("test timing done");
    report_and_stop;
  end
endmodule

// [verilog/ivc_controller.sv]
// Purpose: Vectored interrupt controller with APB registers
// Assumes: Timer and time base events are one-clock pulses on clk
// Notes: Pin passes a two-flop synchroniser; core signals are same domain
//
// The register offsets and the APB slave port were chosen for this implementation.
`timescale 1ns/1ns
module ivc_controller #(
  parameter int NUM_TIMERS = 3,
  parameter bit TB_VEC_ALT = 1'b0
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sharedIrqPin,
  input wire logic [2:0] timerOvf,
  input wire logic timebaseEvt,
  input wire ivc_pkg::ivc_core_in_s coreIn,
  output ivc_pkg::ivc_core_out_s coreOut
);

  // ==========================================================
  // Declarations
  localparam logic [4:0] SRC_PRESENT = {1'b1, (NUM_TIMERS >= 3), (NUM_TIMERS >= 2), 2'h3};

  logic pinSync;
  logic pinPrev;
  logic t2Pulse;
  logic cycEnd;
  logic extEdge;
  logic [4:0] events;
  logic [4:0] flags;
  logic [4:0] next_flags;
  logic [4:0] ens;
  logic [4:0] next_ens;
  logic globalEn;
  logic next_globalEn;
  logic [7:0] ctrlOne;
  logic [7:0] next_ctrlOne;
  logic [4:0] pending;
  logic decide;
  logic take;
  ivc_pkg::ivc_state_e state;
  ivc_pkg::ivc_state_e next_state;
  logic [1:0] cnt;
  logic [1:0] next_cnt;
  logic [2:0] selIdx;
  logic [2:0] next_selIdx;
  logic accWr;
  logic setupRd;
  logic mapped;
  logic [31:0] rdMux;
  ivc_pkg::ivc_core_out_s next_coreOut;

  // ==========================================================
  // Helpers
  ivc_sync u_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .pinAsync(sharedIrqPin),
    .pinSync(pinSync)
  );

  ivc_phase_div u_phase (
    .clk(clk),
    .sys_rst(sys_rst),
    .t2Pulse(t2Pulse),
    .cycEnd(cycEnd)
  );

  // Lowest index wins, external first
  function automatic logic [2:0] pickSource(input logic [4:0] req);
    logic [2:0] idx;
    idx = ivc_pkg::SRC_TB;
    for (int i = ivc_pkg::NUM_SRC - 1; i >= 0; i--) begin
      if (req[i]) begin
        idx = 3'(i);
      end
    end
    return idx;
  endfunction

  // Time base slot depends on how many timers exist
  function automatic logic [7:0] vectorOf(input logic [2:0] idx);
    logic [7:0] v;
    v = ivc_pkg::VEC_EXT;
    unique case (idx)
      ivc_pkg::SRC_T0: v = ivc_pkg::VEC_T0;
      ivc_pkg::SRC_T1: v = ivc_pkg::VEC_T1;
      ivc_pkg::SRC_T2: v = ivc_pkg::VEC_T2;
      ivc_pkg::SRC_TB: begin
        if (NUM_TIMERS >= 3) begin
          v = ivc_pkg::VEC_TB_THREE;
        end else if (NUM_TIMERS == 2) begin
          v = TB_VEC_ALT ? ivc_pkg::VEC_TB_TWO_ALT : ivc_pkg::VEC_TB_TWO;
        end else begin
          v = ivc_pkg::VEC_TB_ONE;
        end
      end
      default: v = ivc_pkg::VEC_EXT;
    endcase
    return v;
  endfunction

  // ==========================================================
  // Pin edge detection on the synchronised sample
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pinPrev <= 1'b0;
    end else begin
      pinPrev <= pinSync;
    end
  end

  always_comb begin
    unique case (ctrlOne[ivc_pkg::ONE_EDGE_HI:ivc_pkg::ONE_EDGE_LO])
      ivc_pkg::EDGE_OFF: extEdge = 1'b0;
      ivc_pkg::EDGE_RISE: extEdge = pinSync & ~pinPrev;
      ivc_pkg::EDGE_FALL: extEdge = ~pinSync & pinPrev;
      ivc_pkg::EDGE_BOTH: extEdge = pinSync ^ pinPrev;
    endcase
  end

  // Absent timers never raise requests
  assign events = {timebaseEvt, timerOvf, extEdge} & SRC_PRESENT;
  assign pending = flags & ens & SRC_PRESENT;

  // ==========================================================
  // APB decode: zero wait states, read data captured in setup
  assign accWr = psel & penable & pwrite & pready;
  assign setupRd = psel & ~penable & ~pwrite;
  assign mapped = (paddr == ivc_pkg::ADDR_CTRL_A) | (paddr == ivc_pkg::ADDR_CTRL_B)
                | (paddr == ivc_pkg::ADDR_CTRL_ONE) | (paddr == ivc_pkg::ADDR_STATUS);
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;

  // Read view of the register file
  always_comb begin
    rdMux = 32'h0000_0000;
    unique case (paddr)
      ivc_pkg::ADDR_CTRL_A: begin
        rdMux[ivc_pkg::A_GLOBAL_EN] = globalEn;
        rdMux[ivc_pkg::A_EXT_EN] = ens[ivc_pkg::SRC_EXT];
        rdMux[ivc_pkg::A_T0_EN] = ens[ivc_pkg::SRC_T0];
        rdMux[ivc_pkg::A_T1_EN] = ens[ivc_pkg::SRC_T1];
        rdMux[ivc_pkg::A_EXT_FLAG] = flags[ivc_pkg::SRC_EXT];
        rdMux[ivc_pkg::A_T0_FLAG] = flags[ivc_pkg::SRC_T0];
        rdMux[ivc_pkg::A_T1_FLAG] = flags[ivc_pkg::SRC_T1];
      end
      ivc_pkg::ADDR_CTRL_B: begin
        rdMux[ivc_pkg::B_T2_EN] = ens[ivc_pkg::SRC_T2];
        rdMux[ivc_pkg::B_TB_EN] = ens[ivc_pkg::SRC_TB];
        rdMux[ivc_pkg::B_T2_FLAG] = flags[ivc_pkg::SRC_T2];
        rdMux[ivc_pkg::B_TB_FLAG] = flags[ivc_pkg::SRC_TB];
      end
      ivc_pkg::ADDR_CTRL_ONE: rdMux[7:0] = ctrlOne;
      ivc_pkg::ADDR_STATUS: rdMux[15:0] = {3'h0, selIdx, state, coreOut.irqVector};
      default: rdMux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      prdata <= 32'h0000_0000;
    end else if (setupRd) begin
      prdata <= rdMux;
    end
  end

  // ==========================================================
  // Flags and enables: write, then service clear, then hardware set
  always_comb begin
    next_flags = flags;
    next_ens = ens;
    next_globalEn = globalEn;
    next_ctrlOne = ctrlOne;
    if (accWr && paddr == ivc_pkg::ADDR_CTRL_A) begin
      next_globalEn = pwdata[ivc_pkg::A_GLOBAL_EN];
      next_ens[ivc_pkg::SRC_EXT] = pwdata[ivc_pkg::A_EXT_EN];
      next_ens[ivc_pkg::SRC_T0] = pwdata[ivc_pkg::A_T0_EN];
      next_ens[ivc_pkg::SRC_T1] = pwdata[ivc_pkg::A_T1_EN];
      next_flags[ivc_pkg::SRC_EXT] = pwdata[ivc_pkg::A_EXT_FLAG];
      next_flags[ivc_pkg::SRC_T0] = pwdata[ivc_pkg::A_T0_FLAG];
      next_flags[ivc_pkg::SRC_T1] = pwdata[ivc_pkg::A_T1_FLAG];
    end
    if (accWr && paddr == ivc_pkg::ADDR_CTRL_B) begin
      next_ens[ivc_pkg::SRC_T2] = pwdata[ivc_pkg::B_T2_EN];
      next_ens[ivc_pkg::SRC_TB] = pwdata[ivc_pkg::B_TB_EN];
      next_flags[ivc_pkg::SRC_T2] = pwdata[ivc_pkg::B_T2_FLAG];
      next_flags[ivc_pkg::SRC_TB] = pwdata[ivc_pkg::B_TB_FLAG];
    end
    if (accWr && paddr == ivc_pkg::ADDR_CTRL_ONE) begin
      next_ctrlOne = pwdata[7:0];
    end
    if (take) begin
      next_flags[selIdx] = 1'b0;
      next_globalEn = 1'b0;
    end
    // Set beats clear so a same-cycle event is never lost
    next_flags = (next_flags | events) & SRC_PRESENT;
    next_ens = next_ens & SRC_PRESENT;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      flags <= 5'h00;
      ens <= 5'h00;
      globalEn <= 1'b0;
      ctrlOne <= ivc_pkg::CTRL_ONE_RESET;
    end else begin
      flags <= next_flags;
      ens <= next_ens;
      globalEn <= next_globalEn;
      ctrlOne <= next_ctrlOne;
    end
  end

  // ==========================================================
  // Service sequencer: choose at phase two, jump at a cycle end
  assign decide = (state == ivc_pkg::IVC_IDLE) & t2Pulse & globalEn & (|pending)
                & ~coreIn.stackFull;
  // A full stack at the jump holds it off until the pointer drops
  assign take = (state != ivc_pkg::IVC_IDLE) & cycEnd & (cnt == 2'h0) & ~coreIn.stackFull;

  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_selIdx = selIdx;
    unique case (state)
      ivc_pkg::IVC_IDLE: begin
        if (decide) begin
          next_selIdx = pickSource(pending);
          if (coreIn.sleepMode) begin
            next_state = ivc_pkg::IVC_WAKE;
            next_cnt = ivc_pkg::WAKE_CYCLES - 2'h1;
          end else begin
            next_state = ivc_pkg::IVC_WAIT;
            next_cnt = ivc_pkg::RUN_CYCLES - 2'h1;
          end
        end
      end
      ivc_pkg::IVC_WAIT, ivc_pkg::IVC_WAKE: begin
        if (take) begin
          next_state = ivc_pkg::IVC_IDLE;
        end else if (cycEnd && cnt != 2'h0) begin
          next_cnt = cnt - 2'h1;
        end
      end
      default: next_state = ivc_pkg::IVC_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state <= ivc_pkg::IVC_IDLE;
      cnt <= 2'h0;
      selIdx <= 3'h0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      selIdx <= next_selIdx;
    end
  end

  // ==========================================================
  // Core commands, all registered
  always_comb begin
    next_coreOut = coreOut;
    next_coreOut.takeIrq = take;
    next_coreOut.popStack = coreIn.retiExec;
    next_coreOut.wakeReq = |pending;
    if (take) begin
      next_coreOut.irqVector = vectorOf(selIdx);
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      coreOut <= '0;
    end else begin
      coreOut <= next_coreOut;
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence runDecide;
    decide && !coreIn.sleepMode;
  endsequence

  sequence wakeDecide;
    decide && coreIn.sleepMode;
  endsequence

  AST_EXT_EDGE_SETS: assert property (
    extEdge |=> flags[ivc_pkg::SRC_EXT])
    else $error("pin edge did not set external flag");

  AST_VECTOR_LOAD: assert property (
    take && selIdx == ivc_pkg::SRC_T0 |=> coreOut.takeIrq && coreOut.irqVector == 8'h08)
    else $error("timer 0 vector wrong");

  AST_RETURN_FROM_INTERRUPT_POP: assert property (
    coreIn.retiExec |=> coreOut.popStack)
    else $error("return did not pop stack");

  AST_GLOBAL_CLEARED: assert property (
    coreOut.takeIrq |-> !globalEn ##1 !coreOut.takeIrq)
    else $error("global enable not cleared on accept");

  AST_FLAG_HOLDS: assert property (
    flags[ivc_pkg::SRC_T0] && !take && !accWr |=> flags[ivc_pkg::SRC_T0])
    else $error("request flag dropped");

  AST_NO_TAKE_FULL: assert property (
    coreIn.stackFull |=> !coreOut.takeIrq)
    else $error("accept while stack full");

  AST_RUN_LATENCY: assert property (
    runDecide ##6 !coreIn.stackFull |=> coreOut.takeIrq)
    else $error("running jump latency wrong");

  AST_WAKE_LATENCY: assert property (
    wakeDecide ##10 !coreIn.stackFull |=> coreOut.takeIrq)
    else $error("wake jump latency wrong");

  AST_EXT_FIRST: assert property (
    decide && pending[ivc_pkg::SRC_EXT] |=> selIdx == ivc_pkg::SRC_EXT)
    else $error("external not chosen first");

endmodule

// [verilog/ivc_phase_div.sv]
// Purpose: Instruction-cycle phase divider
// Assumes: Fixed clocks per instruction cycle
// Notes: Emits the phase-two pulse and end-of-cycle pulse
`timescale 1ns/1ns
module ivc_phase_div #(
  parameter int PHASES = ivc_pkg::CLK_PER_CYC
) (
  input wire logic clk,
  input wire logic sys_rst,
  output logic t2Pulse,
  output logic cycEnd
);

  logic [$clog2(PHASES)-1:0] phase;
  logic [$clog2(PHASES)-1:0] next_phase;

  // ==========================================================
  // Phase counter wraps every instruction cycle
  always_comb begin
    if (phase == ($clog2(PHASES))'(PHASES - 1)) begin
      next_phase = '0;
    end else begin
      next_phase = phase + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      phase <= '0;
    end else begin
      phase <= next_phase;
    end
  end

  // Enables, one clock wide
  assign t2Pulse = (phase == ($clog2(PHASES))'(ivc_pkg::T2_PHASE));
  assign cycEnd = (phase == ($clog2(PHASES))'(PHASES - 1));

endmodule

// [verilog/ivc_pkg.sv]
// Purpose: Shared constants and types for the vectored interrupt controller
// Assumes: One 250 MHz clock, APB register access, core sequencer on the far side
// Notes: Behaviour list below; tags are referenced from the design files
//
// Behaviour
// - Overflow, time base, pin edge set flags
// - Accept pushes next PC, loads vector
// - Return-from-interrupt pops saved PC
// - Accepting clears global enable, blocks nesting
// - Flags still latch while globally disabled
// - Full stack blocks every acknowledge
// - Running: jump 2 or 3 cycles later
// - Wake from sleep: jump 3 cycles later
// - Requests serviced at next phase-two pulse
// - One timer: ext, timer0, time base
// - Two timers: timer1 0CH, time base later
// - Three timers: timer2 10H, base 18H
// - External beats simultaneous internal request
// - Per-source enables plus global gate
// - External needs global, own enable, flag
// - Edge select: off, rise, fall, both
// - External service clears its flag, global
// - Flags hold until serviced or cleared
// - Timer, time base flags auto-clear on service
// - Any enabled source wakes the core
package ivc_pkg;

  // ==========================================================
  // Register map (word aligned byte addresses)
  localparam int ADDR_W = 12;
  localparam logic [11:0] ADDR_CTRL_A = 12'h000;
  localparam logic [11:0] ADDR_CTRL_B = 12'h004;
  localparam logic [11:0] ADDR_CTRL_ONE = 12'h008;
  localparam logic [11:0] ADDR_STATUS = 12'h00C;

  // ==========================================================
  // Field positions, control register A
  localparam int A_GLOBAL_EN = 0;
  localparam int A_EXT_EN = 1;
  localparam int A_T0_EN = 2;
  localparam int A_T1_EN = 3;
  localparam int A_EXT_FLAG = 4;
  localparam int A_T0_FLAG = 5;
  localparam int A_T1_FLAG = 6;
  // Field positions, control register B
  localparam int B_T2_EN = 0;
  localparam int B_TB_EN = 2;
  localparam int B_T2_FLAG = 4;
  localparam int B_TB_FLAG = 6;
  // Field positions, control register one
  localparam int ONE_EDGE_LO = 6;
  localparam int ONE_EDGE_HI = 7;
  localparam logic [7:0] CTRL_ONE_RESET = 8'h00;

  // ==========================================================
  // Source indices, lowest index wins
  localparam int NUM_SRC = 5;
  localparam logic [2:0] SRC_EXT = 3'h0;
  localparam logic [2:0] SRC_T0 = 3'h1;
  localparam logic [2:0] SRC_T1 = 3'h2;
  localparam logic [2:0] SRC_T2 = 3'h3;
  localparam logic [2:0] SRC_TB = 3'h4;

  // Edge select codes
  localparam logic [1:0] EDGE_OFF = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;

  // ==========================================================
  // Vector addresses
  localparam logic [7:0] VEC_EXT = 8'h04;
  localparam logic [7:0] VEC_T0 = 8'h08;
  localparam logic [7:0] VEC_T1 = 8'h0C;
  localparam logic [7:0] VEC_T2 = 8'h10;
  localparam logic [7:0] VEC_TB_ONE = 8'h0C;
  localparam logic [7:0] VEC_TB_TWO = 8'h10;
  localparam logic [7:0] VEC_TB_TWO_ALT = 8'h14;
  localparam logic [7:0] VEC_TB_THREE = 8'h18;

  // ==========================================================
  // Timing in instruction cycles and clocks
  localparam int CLK_PER_CYC = 4;
  localparam int T2_PHASE = 1;
  localparam logic [1:0] RUN_CYCLES = 2'h2;
  localparam logic [1:0] WAKE_CYCLES = 2'h3;

  typedef enum logic [1:0] {
    IVC_IDLE = 2'h0,
    IVC_WAIT = 2'h1,
    IVC_WAKE = 2'h2
  } ivc_state_e;

  // Requests from the core sequencer
  typedef struct packed {
    logic retiExec;
    logic stackFull;
    logic sleepMode;
  } ivc_core_in_s;

  // Commands to the core sequencer
  typedef struct packed {
    logic takeIrq;
    logic popStack;
    logic wakeReq;
    logic [7:0] irqVector;
  } ivc_core_out_s;

endpackage

// [verilog/ivc_sync.sv]
// Purpose: Two-flop synchroniser for the shared interrupt pin
// Assumes: Pin is asynchronous to clk
// Notes: Only the second flop is visible to other logic
`timescale 1ns/1ns
module ivc_sync (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic pinAsync,
  output logic pinSync
);

  logic stageOne;

  // ==========================================================
  // Metastability filter
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      stageOne <= 1'b0;
      pinSync <= 1'b0;
    end else begin
      stageOne <= pinAsync;
      pinSync <= stageOne;
    end
  end

endmodule
